// ==== rtl/tal_table_access.sv ====
// Table access unit: moves 16-bit program words to and from 8-bit data space.
// Assumes program memory read data one cycle after rd, and a core that stalls while halt is high.
`timescale 1ns/1ns
`default_nettype none

module tal_table_access
#(
    parameter logic [15:0] INT_WORDS = 16'h2000
)
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    // Instruction port
    input  wire logic               cmd_valid,
    input  wire tal_pkg::tal_cmd_t  cmd,
    output logic                    cmd_done,
    output logic [7:0]              cmd_rbyte,
    output logic                    halt,
    // Interrupt interaction
    input  wire tal_pkg::tal_irq_t  irq,
    input  wire logic               global_irq_disable,
    output logic [2:0]              irq_flag_clr,
    output logic                    irq_vector_req,
    // Programming voltage pin
    input  wire logic               pgm_voltage_ok,
    // Program memory
    output var tal_pkg::tal_pm_t    pm,
    input  wire logic [15:0]        int_rdata,
    input  wire logic [15:0]        ext_rdata
);
    import tal_pkg::*;

    typedef enum logic [3:0] {
        TAL_ST_IDLE = 4'b0001,
        TAL_ST_WR2  = 4'b0010,
        TAL_ST_LONG = 4'b0100,
        TAL_ST_RD2  = 4'b1000
    } tal_state_t;

    // Highest-priority set bit of the core sources
    function automatic logic [2:0] tal_first(input logic [2:0] v);
        logic [2:0] r;
        r = 3'h0;
        if (v[0])
        begin
            r = 3'h1;
        end
        else if (v[1])
        begin
            r = 3'h2;
        end
        else if (v[2])
        begin
            r = 3'h4;
        end
        return r;
    endfunction

    // External target decision
    function automatic logic tal_is_ext(input logic [1:0] mode, input logic [15:0] addr);
        logic r;
        r = 1'b0;
        if (mode == TAL_MODE_MPU)
        begin
            r = 1'b1;
        end
        else if (mode == TAL_MODE_EXT_MCU)
        begin
            r = (addr >= INT_WORDS);
        end
        return r;
    endfunction

    tal_state_t  st_q, st_d;
    logic [15:0] ptr_q, ptr_d;
    logic [15:0] wlat_q, wlat_d;
    logic [15:0] rlat_q, rlat_d;
    logic [1:0]  mode_q, mode_d;
    logic        inc_q, inc_d;
    logic        ext_q, ext_d;
    logic        abort_q, abort_d;
    logic        vect_q, vect_d;
    logic        done_q, done_d;
    logic [7:0]  rbyte_q, rbyte_d;
    logic [2:0]  clr_q, clr_d;
    logic        vreq_q, vreq_d;
    logic        pgm_q, pgm_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        vpp_s1_q, vpp_s2_q;

    logic [2:0]  core_pend;
    logic        any_pend;
    logic        ext_now;

    assign core_pend = irq.core_en & irq.core_flag;
    assign any_pend  = (|core_pend) | (irq.per_en & irq.per_flag);
    assign ext_now   = tal_is_ext(mode_q, ptr_q);

    assign halt           = (st_q == TAL_ST_LONG);
    assign cmd_done       = done_q;
    assign cmd_rbyte      = rbyte_q;
    assign irq_flag_clr   = clr_q;
    assign irq_vector_req = vreq_q;
    assign reg_rdata      = rdata_q;
    assign pm.addr        = ptr_q;
    assign pm.wdata       = wlat_q;
    assign pm.int_pgm     = pgm_q;
    assign pm.ext_we      = (st_q == TAL_ST_WR2) && ext_q;
    assign pm.rd          = cmd_valid && (st_q == TAL_ST_IDLE) && (cmd.op == TAL_OP_WORD_RD);

    always_comb
    begin
        st_d    = st_q;
        ptr_d   = ptr_q;
        wlat_d  = wlat_q;
        rlat_d  = rlat_q;
        mode_d  = mode_q;
        inc_d   = inc_q;
        ext_d   = ext_q;
        abort_d = abort_q;
        vect_d  = vect_q;
        done_d  = 1'b0;
        rbyte_d = rbyte_q;
        clr_d   = 3'h0;
        vreq_d  = 1'b0;
        pgm_d   = 1'b0;
        rdata_d = TAL_BYTE_ZERO;

        case (st_q)
            TAL_ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    inc_d = cmd.inc;
                    ext_d = ext_now;
                    case (cmd.op)
                        TAL_OP_LATCH_WR:
                        begin
                            if (cmd.hi)
                            begin
                                wlat_d[15:8] = cmd.data;
                            end
                            else
                            begin
                                wlat_d[7:0] = cmd.data;
                            end
                            if (!ext_now)
                            begin
                                rlat_d = wlat_d;
                            end
                            done_d = 1'b1;
                        end
                        TAL_OP_LATCH_RD:
                        begin
                            rbyte_d = cmd.hi ? rlat_q[15:8] : rlat_q[7:0];
                            done_d  = 1'b1;
                        end
                        TAL_OP_WORD_RD:
                        begin
                            rbyte_d = cmd.hi ? rlat_q[15:8] : rlat_q[7:0];
                            st_d    = TAL_ST_RD2;
                        end
                        TAL_OP_WORD_WR:
                        begin
                            abort_d = 1'b0;
                            vect_d  = 1'b0;
                            if (ext_now)
                            begin
                                st_d = TAL_ST_WR2;
                            end
                            else if (any_pend)
                            begin
                                clr_d   = tal_first(core_pend);
                                abort_d = 1'b1;
                                done_d  = 1'b1;
                            end
                            else if (!vpp_s2_q)
                            begin
                                st_d = TAL_ST_WR2;
                            end
                            else
                            begin
                                pgm_d = 1'b1;
                                st_d  = TAL_ST_LONG;
                            end
                        end
                        default:
                        begin
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            TAL_ST_WR2:
            begin
                if (inc_q)
                begin
                    ptr_d = ptr_q + TAL_PTR_STEP;
                end
                done_d = 1'b1;
                st_d   = TAL_ST_IDLE;
            end
            TAL_ST_LONG:
            begin
                if (any_pend)
                begin
                    clr_d  = tal_first(core_pend);
                    vreq_d = !global_irq_disable;
                    vect_d = !global_irq_disable;
                    if (inc_q)
                    begin
                        ptr_d = ptr_q + TAL_PTR_STEP;
                    end
                    done_d = 1'b1;
                    st_d   = TAL_ST_IDLE;
                end
                else
                begin
                    pgm_d = 1'b1;
                end
            end
            TAL_ST_RD2:
            begin
                rlat_d = ext_q ? ext_rdata : int_rdata;
                if (!ext_q)
                begin
                    wlat_d = rlat_d;
                end
                if (inc_q)
                begin
                    ptr_d = ptr_q + TAL_PTR_STEP;
                end
                done_d = 1'b1;
                st_d   = TAL_ST_IDLE;
            end
            default:
            begin
                st_d = TAL_ST_IDLE;
            end
        endcase

        // Register writes win over pointer steps
        if (reg_wr)
        begin
            case (reg_addr)
                TAL_REG_PTR_LO: ptr_d[7:0]  = reg_wdata;
                TAL_REG_PTR_HI: ptr_d[15:8] = reg_wdata;
                TAL_REG_CTRL:   mode_d      = reg_wdata[1:0];
                default:        ;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                TAL_REG_PTR_LO: rdata_d = ptr_q[7:0];
                TAL_REG_PTR_HI: rdata_d = ptr_q[15:8];
                TAL_REG_CTRL:   rdata_d = {6'h00, mode_q};
                TAL_REG_STAT:
                begin
                    rdata_d[TAL_STAT_BUSY]  = halt;
                    rdata_d[TAL_STAT_ABORT] = abort_q;
                    rdata_d[TAL_STAT_VECT]  = vect_q;
                end
                default:        rdata_d = TAL_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q     <= TAL_ST_IDLE;
            ptr_q    <= TAL_PTR_RST;
            wlat_q   <= TAL_LAT_RST;
            rlat_q   <= TAL_LAT_RST;
            mode_q   <= TAL_MODE_RST;
            inc_q    <= 1'b0;
            ext_q    <= 1'b0;
            abort_q  <= 1'b0;
            vect_q   <= 1'b0;
            done_q   <= 1'b0;
            rbyte_q  <= TAL_BYTE_ZERO;
            clr_q    <= 3'h0;
            vreq_q   <= 1'b0;
            pgm_q    <= 1'b0;
            rdata_q  <= TAL_BYTE_ZERO;
            vpp_s1_q <= 1'b0;
            vpp_s2_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            ptr_q    <= ptr_d;
            wlat_q   <= wlat_d;
            rlat_q   <= rlat_d;
            mode_q   <= mode_d;
            inc_q    <= inc_d;
            ext_q    <= ext_d;
            abort_q  <= abort_d;
            vect_q   <= vect_d;
            done_q   <= done_d;
            rbyte_q  <= rbyte_d;
            clr_q    <= clr_d;
            vreq_q   <= vreq_d;
            pgm_q    <= pgm_d;
            rdata_q  <= rdata_d;
            vpp_s1_q <= pgm_voltage_ok;
            vpp_s2_q <= vpp_s1_q;
        end
    end

endmodule // tal_table_access

`default_nettype wire

// ==== rtl/tal_pkg.sv ====
// Constants, types and register map of the table access unit.
// Assumes a core that issues one table instruction at a time and waits for done.
package tal_pkg;

    // Register offsets
    localparam logic [3:0] TAL_REG_PTR_LO = 4'h0;
    localparam logic [3:0] TAL_REG_PTR_HI = 4'h1;
    localparam logic [3:0] TAL_REG_CTRL   = 4'h2;
    localparam logic [3:0] TAL_REG_STAT   = 4'h3;

    // Reset values
    localparam logic [15:0] TAL_PTR_RST   = 16'h0000;
    localparam logic [15:0] TAL_LAT_RST   = 16'h0000;
    localparam logic [1:0]  TAL_MODE_RST  = 2'h0;

    // Status bit positions
    localparam int TAL_STAT_BUSY  = 0;
    localparam int TAL_STAT_ABORT = 1;
    localparam int TAL_STAT_VECT  = 2;

    localparam logic [15:0] TAL_PTR_STEP = 16'h0001;
    localparam logic [7:0]  TAL_BYTE_ZERO = 8'h00;

    // Memory modes
    typedef enum logic [1:0] {
        TAL_MODE_MCU     = 2'h0,
        TAL_MODE_EXT_MCU = 2'h1,
        TAL_MODE_MPU     = 2'h2,
        TAL_MODE_RSV     = 2'h3
    } tal_mode_t;

    // Table instructions
    typedef enum logic [1:0] {
        TAL_OP_LATCH_WR = 2'h0,
        TAL_OP_LATCH_RD = 2'h1,
        TAL_OP_WORD_WR  = 2'h2,
        TAL_OP_WORD_RD  = 2'h3
    } tal_op_t;

    typedef struct packed {
        tal_op_t    op;
        logic       hi;
        logic       inc;
        logic [7:0] data;
    } tal_cmd_t;

    // Core sources in priority order: pin, overflow, clock pin
    localparam int TAL_NCORE = 3;

    typedef struct packed {
        logic [TAL_NCORE-1:0] core_en;
        logic [TAL_NCORE-1:0] core_flag;
        logic                 per_en;
        logic                 per_flag;
    } tal_irq_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        int_pgm;
        logic        ext_we;
        logic        rd;
    } tal_pm_t;

endpackage

// ==== sim/tal_monitor.sv ====
// Checker for the table access unit: long write, interrupt and read timing.
// Assumes it is bound to tal_table_access and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module tal_monitor
(
    // Watched ports
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              cmd_valid,
    input wire tal_pkg::tal_cmd_t cmd,
    input wire logic              cmd_done,
    input wire logic              halt,
    input wire tal_pkg::tal_irq_t irq,
    input wire logic              global_irq_disable,
    input wire logic [2:0]        irq_flag_clr,
    input wire logic              irq_vector_req,
    input wire tal_pkg::tal_pm_t  pm
);
    import tal_pkg::*;
    logic [2:0] core_hit;
    logic       any_en;
    assign core_hit = irq.core_en & irq.core_flag;
    assign any_en = (|core_hit) | (irq.per_en & irq.per_flag);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_lw_hold: assert property (halt && !any_en |=> halt)
        else $error("long write ended without cause");
    a_lw_end: assert property (halt && any_en |=> !halt && cmd_done)
        else $error("long write not ended");
    a_vec_gate: assert property (irq_vector_req |-> $past(halt) && !$past(global_irq_disable))
        else $error("vector without cause");
    a_vec_go: assert property (halt && any_en && !global_irq_disable |=> irq_vector_req)
        else $error("vector missing");
    a_clr_prio: assert property (|irq_flag_clr |-> irq_flag_clr == ($past(core_hit) & (~$past(core_hit) + 3'h1)))
        else $error("wrong flag cleared");
    a_per_keep: assert property (halt && !(|core_hit) |=> irq_flag_clr == 3'h0)
        else $error("peripheral flag cleared");
    a_rd_word: assert property (cmd_valid && cmd.op == TAL_OP_WORD_RD |-> pm.rd ##2 cmd_done)
        else $error("word read timing");
    a_ext_two: assert property (pm.ext_we |=> cmd_done)
        else $error("external write not two cycles");
    a_pgm_halt: assert property (pm.int_pgm |-> halt)
        else $error("programming outside halt");

    c_long: cover property (halt && any_en);
    c_vec: cover property (irq_vector_req);
    c_ext: cover property (pm.ext_we);
endmodule // tal_monitor

bind tal_table_access tal_monitor u_mon (.clk, .rstn, .cmd_valid, .cmd, .cmd_done, .halt, .irq,
    .global_irq_disable, .irq_flag_clr, .irq_vector_req, .pm);

`default_nettype wire

// ==== sim/tal_pmem_model.sv ====
// Program memory model: internal and external word arrays.
// Assumes reads answer one cycle after pm.rd; idle data lines toggle.
`timescale 1ns/1ns
`default_nettype none

module tal_pmem_model
(
    input wire logic             clk,
    input wire tal_pkg::tal_pm_t pm,
    output var logic [15:0]      int_rdata,
    output var logic [15:0]      ext_rdata
);
    import tal_pkg::*;
    logic [15:0] im [256];
    logic [15:0] em [256];
    initial
    begin
        int_rdata = 16'h0000;
        ext_rdata = 16'h0000;
        for (int i = 0; i < 256; i++)
        begin
            im[i] = 16'ha500 + 16'(i);
            em[i] = 16'h5a00 + 16'(i);
        end
    end
    always @(posedge clk)
    begin
        // Stale data inverted so nothing reads as valid
        int_rdata <= pm.rd ? im[pm.addr[7:0]] : ~int_rdata;
        ext_rdata <= pm.rd ? em[pm.addr[7:0]] : ~ext_rdata;
        if (pm.ext_we)
            em[pm.addr[7:0]] <= pm.wdata;
        if (pm.int_pgm)
            im[pm.addr[7:0]] <= pm.wdata;
    end
endmodule // tal_pmem_model

`default_nettype wire

// ==== sim/table_access_long_write_tb.sv ====
// Testbench of the table access unit with the program memory model.
// Assumes nothing beyond the design package.
`timescale 1ns/1ns
`default_nettype none

module table_access_long_write_tb;
    import tal_pkg::*;
    logic        clk, rstn, reg_wr, reg_rd, cmd_valid, cmd_done, halt;
    logic        global_irq_disable, irq_vector_req, pgm_voltage_ok, vec;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, cmd_rbyte, rb, b;
    logic [2:0]  irq_flag_clr, clr;
    logic [15:0] int_rdata, ext_rdata;
    tal_cmd_t    cmd;
    tal_irq_t    irq;
    tal_pm_t     pm;
    int          num_errors, n_compared, cycles;

    tal_table_access #(.INT_WORDS(16'h0010)) u_dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cmd_valid, .cmd, .cmd_done, .cmd_rbyte, .halt, .irq, .global_irq_disable,
        .irq_flag_clr, .irq_vector_req, .pgm_voltage_ok, .pm, .int_rdata, .ext_rdata);
    tal_pmem_model u_mem (.clk, .pm, .int_rdata, .ext_rdata);

    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    task automatic ptr(input logic [15:0] v);
        wr(TAL_REG_PTR_LO, v[7:0]);
        wr(TAL_REG_PTR_HI, v[15:8]);
    endtask
    task automatic op(input tal_op_t o, input logic h, input logic i, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1;
        cmd <= '{o, h, i, d};
        @(posedge clk);
        cmd_valid <= 0;
        #1;
        for (int n = 0; n < 300 && cmd_done !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        chk(cmd_done, 16'h1);
        rb = cmd_rbyte;
        vec = irq_vector_req;
        clr = irq_flag_clr;
    endtask

    task automatic s_regs;
        ptr(16'h1234);
        rd(TAL_REG_PTR_LO, b); chk(b, 16'h34);
        rd(TAL_REG_PTR_HI, b); chk(b, 16'h12);
        @(posedge clk);
        #1 chk(reg_rdata, 16'h0);
        wr(TAL_REG_STAT, 8'hff);
        rd(TAL_REG_STAT, b); chk(b, 16'h0);
        rd(4'h7, b); chk(b, 16'h0);
    endtask
    task automatic s_latch;
        op(TAL_OP_LATCH_WR, 1, 0, 8'hab);
        op(TAL_OP_LATCH_WR, 0, 0, 8'hcd);
        op(TAL_OP_LATCH_RD, 1, 0, 8'h00); chk(rb, 16'hab);
        op(TAL_OP_LATCH_RD, 0, 0, 8'h00); chk(rb, 16'hcd);
        rd(TAL_REG_PTR_LO, b); chk(b, 16'h34);
    endtask
    task automatic s_read;
        ptr(16'h0003);
        op(TAL_OP_WORD_RD, 1, 1, 8'h00); chk(rb, 16'hab);
        op(TAL_OP_LATCH_RD, 1, 0, 8'h00); chk(rb, 16'ha5);
        op(TAL_OP_LATCH_RD, 0, 0, 8'h00); chk(rb, 16'h03);
        rd(TAL_REG_PTR_LO, b); chk(b, 16'h04);
    endtask
    task automatic s_ext;
        wr(TAL_REG_CTRL, 8'h01);
        ptr(16'h0030);
        op(TAL_OP_WORD_RD, 0, 0, 8'h00);
        op(TAL_OP_LATCH_RD, 1, 0, 8'h00); chk(rb, 16'h5a);
        ptr(16'h0008);
        op(TAL_OP_WORD_RD, 0, 0, 8'h00);
        op(TAL_OP_LATCH_RD, 1, 0, 8'h00); chk(rb, 16'ha5);
        wr(TAL_REG_CTRL, 8'h02);
        op(TAL_OP_LATCH_WR, 1, 0, 8'h12);
        op(TAL_OP_LATCH_WR, 0, 0, 8'h34);
        op(TAL_OP_WORD_WR, 0, 1, 8'h00);
        rd(TAL_REG_PTR_LO, b); chk(b, 16'h09);
        op(TAL_OP_WORD_RD, 0, 0, 8'h00);
        op(TAL_OP_WORD_WR, 0, 0, 8'h00);
        ptr(16'h0008);
        op(TAL_OP_WORD_RD, 0, 1, 8'h00);
        op(TAL_OP_WORD_RD, 1, 0, 8'h00); chk(rb, 16'h12);
        op(TAL_OP_LATCH_RD, 0, 0, 8'h00); chk(rb, 16'h34);
        wr(TAL_REG_CTRL, 8'h03);
        rd(TAL_REG_CTRL, b); chk(b, 16'h03);
        ptr(16'h0030);
        op(TAL_OP_WORD_RD, 0, 0, 8'h00);
        op(TAL_OP_LATCH_RD, 1, 0, 8'h00); chk(rb, 16'ha5);
        wr(TAL_REG_CTRL, 8'h00);
    endtask
    task automatic long_wr(input logic gd, input tal_irq_t src);
        @(posedge clk);
        global_irq_disable <= gd;
        fork
            op(TAL_OP_WORD_WR, 0, 1, 8'h00);
            begin
                repeat (8) @(posedge clk);
                #1 chk(halt, 16'h1);
                @(posedge clk);
                irq <= src;
            end
        join
        @(posedge clk);
        irq <= '0;
    endtask
    task automatic s_long;
        ptr(16'h0005);
        op(TAL_OP_LATCH_WR, 1, 0, 8'hab);
        op(TAL_OP_LATCH_WR, 0, 0, 8'hcd);
        long_wr(1, 8'h03);
        chk(vec, 16'h0);
        chk(clr, 16'h0);
        rd(TAL_REG_STAT, b); chk(b, 16'h0);
        long_wr(0, 8'h48);
        chk(vec, 16'h1);
        chk(clr, 16'h2);
        rd(TAL_REG_STAT, b); chk(b, 16'h04);
        ptr(16'h0005);
        op(TAL_OP_WORD_RD, 0, 0, 8'h00);
        op(TAL_OP_LATCH_RD, 0, 0, 8'h00); chk(rb, 16'hcd);
        @(posedge clk);
        irq <= 8'hb4;
        op(TAL_OP_WORD_WR, 0, 1, 8'h00);
        chk(clr, 16'h1);
        chk(vec, 16'h0);
        @(posedge clk);
        irq <= 8'h00;
        rd(TAL_REG_PTR_LO, b); chk(b, 16'h05);
        rd(TAL_REG_STAT, b); chk(b, 16'h02);
    endtask
    task automatic s_novolt;
        @(posedge clk);
        pgm_voltage_ok <= 0;
        ptr(16'h0007);
        op(TAL_OP_WORD_WR, 0, 0, 8'h00);
        op(TAL_OP_WORD_RD, 0, 0, 8'h00);
        op(TAL_OP_LATCH_RD, 0, 0, 8'h00); chk(rb, 16'h07);
    endtask

    initial
    begin
        {rstn, reg_wr, reg_rd, cmd_valid, global_irq_disable} = '0;
        {reg_addr, reg_wdata, cmd, irq, num_errors, n_compared, cycles} = '0;
        pgm_voltage_ok = 1;
        repeat (20) @(posedge clk);
        rstn <= 1;
        s_regs();
        s_latch();
        s_read();
        s_ext();
        s_long();
        s_novolt();
        close_out();
    end
endmodule // table_access_long_write_tb

`default_nettype wire
